// file: hw/msp_pkg.sv
/*
  Shared constants and types of the multimode serial port block: register map, configuration and
  status layouts, circuit indices and bit-time arithmetic.
  Assumes a single 40 MHz core clock and a 32-bit AHB-Lite register bus.

  // Function
  // - Four independent ports, each with own configuration.
  // - Synchronous everywhere; asynchronous only on port zero.
  // - Synchronous bits timed by link or internal clock.
  // - Nine software-selected synchronous rates, full duplex.
  // - Asynchronous timing from internal baud generator.
  // - 7E/7O/7N/8N characters, 1, 1.5 or 2 stops.
  // - Eight software-selected asynchronous rates, full duplex.
  // - Per-port strap picks DTE or DCE circuit directions.
  // - DTE times data from clock the DCE supplies.
  // - Single-ended circuit drivers split between DTE and DCE.
  // - Differential mode drives complementary a/b pairs.
*/
`default_nettype none
package msp_pkg;
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int          NPORTS     = 4;
  localparam int          ASYNC_PORT = 0;
  localparam int          DIV_W      = 19;
  localparam int          NCIRC      = 14;

  // Byte offsets inside one port's window; port p sits at p * PORT_STRIDE.
  localparam logic [3:0] REG_CFG     = 4'h0;
  localparam logic [3:0] REG_STAT    = 4'h4;
  localparam logic [3:0] REG_TXD     = 4'h8;
  localparam logic [3:0] REG_RXD     = 4'hc;
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam int         MAP_TOP_BIT = 6;

  localparam logic [1:0] FMT_7E  = 2'h0;
  localparam logic [1:0] FMT_7O  = 2'h1;
  localparam logic [1:0] FMT_7N  = 2'h2;
  localparam logic [1:0] FMT_8N  = 2'h3;
  localparam logic [1:0] STOP_1  = 2'h0;
  localparam logic [1:0] STOP_15 = 2'h1;
  localparam logic [1:0] STOP_2  = 2'h2;
  localparam logic [3:0] FRAME_9 = 4'h9;
  localparam logic [3:0] FRAME_10 = 4'ha;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam int          STAT_W1C_LSB = 3;

  // Circuit indices of one port connector.
  localparam int C_TXD = 0;
  localparam int C_RXD = 1;
  localparam int C_RTS = 2;
  localparam int C_CTS = 3;
  localparam int C_DSR = 4;
  localparam int C_CD  = 5;
  localparam int C_SCT = 6;
  localparam int C_SCR = 7;
  localparam int C_LL  = 8;
  localparam int C_DTR = 9;
  localparam int C_RL  = 10;
  localparam int C_DRS = 11;
  localparam int C_ETC = 12;
  localparam int C_TM  = 13;
  localparam logic [NCIRC-1:0] DTE_MASK   = 14'h1f05;
  localparam logic [NCIRC-1:0] DCE_MASK   = 14'h20fa;
  localparam logic [NCIRC-1:0] CLK_MASK   = 14'h10c0;
  localparam logic [NCIRC-1:0] DIFF_OFF   = 14'h2d10;
  localparam logic [NCIRC-1:0] PAIR_MASK  = 14'h10c3;

  typedef struct packed {
    logic [4:0] modem;
    logic [1:0] stop;
    logic [1:0] fmt;
    logic [3:0] rate;
    logic       int_clk;
    logic       async_mode;
    logic       enable;
  } msp_cfg_t;
  localparam msp_cfg_t CFG_RESET = 16'h0000;

  typedef struct packed {
    logic [9:0]       zero;
    logic [NCIRC-1:0] pins;
    logic             diff;
    logic             dte;
    logic             ferr;
    logic             perr;
    logic             ovr;
    logic             rvalid;
    logic             tbusy;
    logic             txfull;
  } msp_stat_t;

  typedef struct packed {
    logic [NCIRC-1:0] out_a;
    logic [NCIRC-1:0] out_b;
    logic [NCIRC-1:0] oe_a;
    logic [NCIRC-1:0] oe_b;
  } msp_pins_t;

  // Clock cycles per bit; an unlisted code falls back to the slowest rate.
  function automatic logic [DIV_W-1:0] bit_cycles(input logic async_sel, input logic [3:0] sel,
                                                  input int unsigned clk_hz);
    int unsigned bps;
    bps = 1200;
    if (async_sel) begin
      unique case (sel)
        4'h0: bps = 300;
        4'h1: bps = 600;
        4'h2: bps = 1200;
        4'h3: bps = 2400;
        4'h4: bps = 4800;
        4'h5: bps = 9600;
        4'h6: bps = 19200;
        4'h7: bps = 38400;
        default: bps = 300;
      endcase
    end else begin
      unique case (sel)
        4'h0: bps = 1200;
        4'h1: bps = 2400;
        4'h2: bps = 4800;
        4'h3: bps = 9600;
        4'h4: bps = 19200;
        4'h5: bps = 38400;
        4'h6: bps = 48000;
        4'h7: bps = 56000;
        4'h8: bps = 64000;
        default: bps = 1200;
      endcase
    end
    return DIV_W'(clk_hz / bps);
  endfunction
endpackage
`default_nettype wire

// file: hw/msp_sync2.sv
/*
  Two-flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level whose bits need not arrive together.
*/
`timescale 1ns/1ps
`default_nettype none
module msp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } msp_sync_st_t;

  msp_sync_st_t s;
  msp_sync_st_t next_s;

  always_comb begin
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;
endmodule
`default_nettype wire

// file: hw/msp_rate_gen.sv
/*
  Internal bit clock generator: a square wave of one bit period.
  Assumes the half period is at least one cycle while enabled.
*/
`timescale 1ns/1ps
`default_nettype none
module msp_rate_gen (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // Control
  input  wire logic                     enable,
  input  wire logic [msp_pkg::DIV_W-1:0] half_cycles,
  // Clock out
  output logic                          bit_clk
);
  typedef struct packed {
    logic [msp_pkg::DIV_W-1:0] cnt;
    logic                      clk;
  } msp_rate_st_t;

  msp_rate_st_t s;
  msp_rate_st_t next_s;

  always_comb begin
    next_s = s;
    if (!enable) begin
      next_s = '0;
    end else if (s.cnt == '0) begin
      next_s.cnt = half_cycles - 1'b1;
      next_s.clk = ~s.clk;
    end else begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bit_clk = s.clk;
endmodule
`default_nettype wire

// file: hw/msp_top.sv
/*
  Four-port serial block: AHB-Lite register slave, per-port synchronous transmit and
  receive engines, asynchronous ones on port zero only, and DTE/DCE pin steering.
  Assumes pins and straps come from outside the clock domain, and that the
  link clocks are far slower than ref_clk so that edges can be found by sampling.
*/
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module msp_top #(
  parameter int          NPORTS = msp_pkg::NPORTS,
  parameter int unsigned CLK_HZ = msp_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic                                 ref_clk,
  input  wire logic                                 reset,
  // AHB-Lite slave
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic      [31:0]                          hrdata,
  // Straps
  input  wire logic [NPORTS-1:0]                    dte_strap,
  input  wire logic [NPORTS-1:0]                    diff_strap,
  // Connector circuits
  input  wire logic [NPORTS-1:0][msp_pkg::NCIRC-1:0] pin_in,
  output msp_pkg::msp_pins_t [NPORTS-1:0]           pin_drv
);
  localparam int PW = $clog2(NPORTS);

  typedef struct packed {
    msp_pkg::msp_cfg_t             cfg;
    logic [7:0]                    txbuf;
    logic                          txfull;
    logic [9:0]                    tsh;
    logic [3:0]                    tcnt;
    logic [msp_pkg::DIV_W-1:0]     tdiv;
    logic                          txd;
    logic [9:0]                    rsh;
    logic [3:0]                    rcnt;
    logic [msp_pkg::DIV_W-1:0]     rdiv;
    logic                          rbusy;
    logic [7:0]                    rxbuf;
    logic                          rvalid;
    logic                          ovr;
    logic                          perr;
    logic                          ferr;
    logic                          tclk_q;
    logic                          rclk_q;
    logic [msp_pkg::NCIRC-1:0]     pout;
    logic [msp_pkg::NCIRC-1:0]     poe;
  } msp_port_st_t;

  typedef struct packed {
    msp_port_st_t [NPORTS-1:0] port;
    logic                      dp_valid;
    logic                      dp_wr;
    logic [5:0]                dp_addr;
    logic [31:0]               rdata;
  } msp_st_t;

  msp_st_t s;
  msp_st_t next_s;

  logic [NPORTS-1:0][msp_pkg::NCIRC-1:0] pin_s;
  logic [NPORTS-1:0]                     dte_s;
  logic [NPORTS-1:0]                     diff_s;
  logic [NPORTS-1:0]                     iclk;
  logic [NPORTS-1:0][msp_pkg::DIV_W-1:0] half_bit;
  logic [NPORTS-1:0]                     iclk_en;

  msp_sync2 #(
    .W (NPORTS * (msp_pkg::NCIRC + 2))
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       ({pin_in, dte_strap, diff_strap}),
    .q       ({pin_s, dte_s, diff_s})
  );

  for (genvar g = 0; g < NPORTS; g++) begin : g_rate
    assign half_bit[g] = msp_pkg::bit_cycles(1'b0, s.port[g].cfg.rate, CLK_HZ) >> 1;
    assign iclk_en[g]  = s.port[g].cfg.enable & s.port[g].cfg.int_clk & ~s.port[g].cfg.async_mode;
    msp_rate_gen u_rate (
      .ref_clk     (ref_clk),
      .reset       (reset),
      .enable      (iclk_en[g]),
      .half_cycles (half_bit[g]),
      .bit_clk     (iclk[g])
    );
    assign pin_drv[g].out_a = s.port[g].pout;
    assign pin_drv[g].oe_a  = s.port[g].poe;
    assign pin_drv[g].out_b = ~s.port[g].pout;
    assign pin_drv[g].oe_b  = diff_s[g] ? (s.port[g].poe & msp_pkg::PAIR_MASK) : '0;
  end

  // Status word of one port, also used by the read mux.
  function automatic msp_pkg::msp_stat_t stat_of(input msp_port_st_t p, input logic [13:0] pins,
                                                 input logic dte, input logic diff);
    msp_pkg::msp_stat_t st;
    st        = '0;
    st.pins   = pins;
    st.diff   = diff;
    st.dte    = dte;
    st.ferr   = p.ferr;
    st.perr   = p.perr;
    st.ovr    = p.ovr;
    st.rvalid = p.rvalid;
    st.tbusy  = p.tcnt != '0;
    st.txfull = p.txfull;
    return st;
  endfunction

  always_comb begin
    logic                      take;
    logic                      wr_now;
    logic [PW-1:0]             ap_port;
    logic [PW-1:0]             dp_port;
    logic [3:0]                ap_reg;
    logic [3:0]                dp_reg;
    logic                      ap_hit;
    logic                      dp_hit;
    logic                      dte;
    logic                      async_on;
    logic                      tclk;
    logic                      rclk;
    logic                      rxd;
    logic                      tx_edge;
    logic                      rx_edge;
    logic [msp_pkg::DIV_W-1:0] bitc;
    logic [msp_pkg::DIV_W-1:0] stopc;
    logic [3:0]                nbits;
    logic [9:0]                frame;
    logic [9:0]                nr;
    logic [7:0]                data;
    logic                      par;
    logic                      par_bad;
    logic [13:0]               drive;
    logic [13:0]               val;
    msp_pkg::msp_cfg_t         wcfg;
    msp_port_st_t              p;
    take     = '0;
    wr_now   = '0;
    ap_port  = '0;
    dp_port  = '0;
    ap_reg   = '0;
    dp_reg   = '0;
    ap_hit   = '0;
    dp_hit   = '0;
    dte      = '0;
    async_on = '0;
    tclk     = '0;
    rclk     = '0;
    rxd      = '0;
    tx_edge  = '0;
    rx_edge  = '0;
    bitc     = '0;
    stopc    = '0;
    nbits    = '0;
    frame    = '0;
    nr       = '0;
    data     = '0;
    par      = '0;
    par_bad  = '0;
    drive    = '0;
    val      = '0;
    wcfg     = '0;
    p        = '0;
    next_s   = s;

    // Address phase: decode, register the read answer, apply read side effects.
    take    = hsel & htrans[1] & hready;
    ap_port = haddr[PW+3:4];
    ap_reg  = {haddr[3:2], 2'b00};
    ap_hit  = (haddr[31:msp_pkg::MAP_TOP_BIT] == '0) && (int'(haddr[5:4]) < NPORTS);
    next_s.dp_valid = take & ap_hit;
    next_s.dp_wr    = hwrite;
    next_s.dp_addr  = haddr[5:0];
    if (take && !hwrite) begin
      next_s.rdata = '0;
      if (ap_hit) begin
        unique case (ap_reg)
          msp_pkg::REG_CFG:  next_s.rdata = 32'(s.port[ap_port].cfg);
          msp_pkg::REG_STAT: next_s.rdata = stat_of(s.port[ap_port], pin_s[ap_port],
                                                    dte_s[ap_port], diff_s[ap_port]);
          msp_pkg::REG_TXD:  next_s.rdata = 32'(s.port[ap_port].txbuf);
          msp_pkg::REG_RXD: begin
            next_s.rdata = 32'(s.port[ap_port].rxbuf);
            next_s.port[ap_port].rvalid = 1'b0;
          end
        endcase
      end
    end
    dp_port = s.dp_addr[PW+3:4];
    dp_reg  = {s.dp_addr[3:2], 2'b00};
    dp_hit  = int'(s.dp_addr[5:4]) < NPORTS;
    wr_now  = s.dp_valid & s.dp_wr & dp_hit;

    for (int i = 0; i < NPORTS; i++) begin
      p = next_s.port[i];
      // Data phase write; engines below see the new values one cycle later.
      if (wr_now && int'(dp_port) == i) begin
        unique case (dp_reg)
          msp_pkg::REG_CFG: begin
            wcfg = hwdata[15:0];
            if (i != msp_pkg::ASYNC_PORT) begin
              wcfg.async_mode = 1'b0;
            end
            p.cfg = wcfg;
          end
          msp_pkg::REG_STAT: begin
            if (hwdata[msp_pkg::STAT_W1C_LSB]) p.ovr = 1'b0;
            if (hwdata[msp_pkg::STAT_W1C_LSB+1]) p.perr = 1'b0;
            if (hwdata[msp_pkg::STAT_W1C_LSB+2]) p.ferr = 1'b0;
          end
          msp_pkg::REG_TXD: begin
            if (!s.port[i].txfull) begin
              p.txbuf  = hwdata[7:0];
              p.txfull = 1'b1;
            end
          end
        endcase
      end

      dte      = dte_s[i];
      async_on = s.port[i].cfg.async_mode;
      bitc     = msp_pkg::bit_cycles(async_on, s.port[i].cfg.rate, CLK_HZ);
      unique case (s.port[i].cfg.stop)
        msp_pkg::STOP_15: stopc = bitc + (bitc >> 1);
        msp_pkg::STOP_2:  stopc = bitc << 1;
        default:          stopc = bitc;
      endcase
      nbits = (s.port[i].cfg.fmt == msp_pkg::FMT_7N) ? msp_pkg::FRAME_9 : msp_pkg::FRAME_10;
      rxd   = dte ? pin_s[i][msp_pkg::C_RXD] : pin_s[i][msp_pkg::C_TXD];

      // A DTE takes its timing from the DCE unless told to run on its own clock.
      if (s.port[i].cfg.int_clk) begin
        tclk = iclk[i];
        rclk = iclk[i];
      end else if (dte) begin
        tclk = pin_s[i][msp_pkg::C_SCT];
        rclk = pin_s[i][msp_pkg::C_SCR];
      end else begin
        tclk = pin_s[i][msp_pkg::C_ETC];
        rclk = pin_s[i][msp_pkg::C_ETC];
      end
      tx_edge  = s.port[i].tclk_q & ~tclk;
      rx_edge  = ~s.port[i].rclk_q & rclk;
      p.tclk_q = tclk;
      p.rclk_q = rclk;

      if (!s.port[i].cfg.enable) begin
        p.tcnt  = '0;
        p.tdiv  = '0;
        p.txd   = 1'b1;
        p.rcnt  = '0;
        p.rdiv  = '0;
        p.rbusy = 1'b0;
      end else if (async_on) begin
        // Transmitter: start, data, optional parity, then a stop of chosen length.
        if (s.port[i].tcnt == '0) begin
          if (s.port[i].txfull) begin
            unique case (s.port[i].cfg.fmt)
              msp_pkg::FMT_8N: frame = {1'b1, s.port[i].txbuf, 1'b0};
              msp_pkg::FMT_7N: frame = {2'b11, s.port[i].txbuf[6:0], 1'b0};
              msp_pkg::FMT_7E: frame = {1'b1, ^s.port[i].txbuf[6:0], s.port[i].txbuf[6:0], 1'b0};
              default:         frame = {1'b1, ~^s.port[i].txbuf[6:0], s.port[i].txbuf[6:0], 1'b0};
            endcase
            p.tsh    = frame;
            p.tcnt   = nbits;
            p.tdiv   = bitc - 1'b1;
            p.txd    = frame[0];
            p.txfull = 1'b0;
          end
        end else if (s.port[i].tdiv != '0) begin
          p.tdiv = s.port[i].tdiv - 1'b1;
        end else if (s.port[i].tcnt == 4'h1) begin
          p.tcnt = '0;
        end else begin
          p.tsh  = s.port[i].tsh >> 1;
          p.txd  = s.port[i].tsh[1];
          p.tcnt = s.port[i].tcnt - 1'b1;
          p.tdiv = ((s.port[i].tcnt == 4'h2) ? stopc : bitc) - 1'b1;
        end
        // Receiver: half a bit into the start bit, then one sample per bit.
        if (!s.port[i].rbusy) begin
          if (!rxd) begin
            p.rbusy = 1'b1;
            p.rcnt  = '0;
            p.rdiv  = (bitc >> 1) - 1'b1;
          end
        end else if (s.port[i].rdiv != '0) begin
          p.rdiv = s.port[i].rdiv - 1'b1;
        end else if (s.port[i].rcnt == '0) begin
          // A start bit gone high by mid-bit was a glitch, not a character.
          p.rbusy = ~rxd;
          p.rcnt  = 4'h1;
          p.rdiv  = bitc - 1'b1;
        end else begin
          nr    = {rxd, s.port[i].rsh[9:1]};
          p.rsh = nr;
          if (s.port[i].rcnt == nbits - 1'b1) begin
            p.rbusy = 1'b0;
            unique case (s.port[i].cfg.fmt)
              msp_pkg::FMT_8N: data = nr[8:1];
              msp_pkg::FMT_7N: data = {1'b0, nr[8:2]};
              default:         data = {1'b0, nr[7:1]};
            endcase
            par     = nr[8];
            par_bad = (s.port[i].cfg.fmt == msp_pkg::FMT_7E) ? (^{par, data[6:0]}) :
                      (s.port[i].cfg.fmt == msp_pkg::FMT_7O) ? ~(^{par, data[6:0]}) : 1'b0;
            p.rxbuf = data;
            p.ovr   = p.ovr | p.rvalid;
            p.rvalid = 1'b1;
            p.perr  = p.perr | par_bad;
            p.ferr  = p.ferr | ~rxd;
          end else begin
            p.rcnt = s.port[i].rcnt + 1'b1;
            p.rdiv = bitc - 1'b1;
          end
        end
      end else begin
        // Synchronous, packet transparent: bytes back to back, idle fill is all ones.
        if (tx_edge) begin
          if (s.port[i].tcnt == '0) begin
            data     = s.port[i].txfull ? s.port[i].txbuf : 8'hff;
            p.txfull = p.txfull & ~s.port[i].txfull;
            p.txd    = data[0];
            p.tsh    = {2'b00, data};
            p.tcnt   = msp_pkg::SYNC_BITS - 1'b1;
          end else begin
            p.txd  = s.port[i].tsh[1];
            p.tsh  = s.port[i].tsh >> 1;
            p.tcnt = s.port[i].tcnt - 1'b1;
          end
        end
        if (rx_edge) begin
          nr    = {2'b00, rxd, s.port[i].rsh[7:1]};
          p.rsh = nr;
          if (s.port[i].rcnt == msp_pkg::SYNC_BITS - 1'b1) begin
            p.rcnt   = '0;
            p.rxbuf  = nr[7:0];
            p.ovr    = p.ovr | p.rvalid;
            p.rvalid = 1'b1;
          end else begin
            p.rcnt = s.port[i].rcnt + 1'b1;
          end
        end
      end

      // Pin steering: each end drives only its own circuits.
      drive = dte ? msp_pkg::DTE_MASK : msp_pkg::DCE_MASK;
      if (!(s.port[i].cfg.int_clk && !async_on)) begin
        drive = drive & ~msp_pkg::CLK_MASK;
      end
      if (diff_s[i]) begin
        drive = drive & ~msp_pkg::DIFF_OFF;
      end
      val = '1;
      if (dte) begin
        val[msp_pkg::C_TXD] = s.port[i].txd;
        val[msp_pkg::C_RTS] = s.port[i].cfg.modem[0];
        val[msp_pkg::C_DTR] = s.port[i].cfg.modem[1];
        val[msp_pkg::C_LL]  = s.port[i].cfg.modem[2];
        val[msp_pkg::C_RL]  = s.port[i].cfg.modem[3];
        val[msp_pkg::C_DRS] = s.port[i].cfg.modem[4];
        val[msp_pkg::C_ETC] = iclk[i];
      end else begin
        val[msp_pkg::C_RXD] = s.port[i].txd;
        val[msp_pkg::C_CTS] = s.port[i].cfg.modem[0];
        val[msp_pkg::C_DSR] = s.port[i].cfg.modem[1];
        val[msp_pkg::C_CD]  = s.port[i].cfg.modem[2];
        val[msp_pkg::C_TM]  = s.port[i].cfg.modem[3];
        val[msp_pkg::C_SCT] = iclk[i];
        val[msp_pkg::C_SCR] = iclk[i];
      end
      p.pout = val;
      p.poe  = s.port[i].cfg.enable ? drive : '0;
      next_s.port[i] = p;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      for (int i = 0; i < NPORTS; i++) begin
        s.port[i].cfg  <= msp_pkg::CFG_RESET;
        s.port[i].txd  <= 1'b1;
        s.port[i].pout <= '1;
      end
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s.rdata;
endmodule
`default_nettype wire

// file: testbench/msp_top_checker.sv
/*
  Concurrent checks on the ports of the four-port serial block.
  Assumes straps stay constant during a run and the bench ties hready to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module msp_top_checker #(
  parameter int          NPORTS = 4,
  parameter int unsigned CLK_HZ = 40000000
) (
  // Clock and reset
  input wire logic                                  ref_clk,
  input wire logic                                  reset,
  // Bus
  input wire logic                                  hsel,
  input wire logic [31:0]                           haddr,
  input wire logic [1:0]                            htrans,
  input wire logic                                  hwrite,
  input wire logic                                  hready,
  input wire logic                                  hreadyout,
  input wire logic                                  hresp,
  input wire logic [31:0]                           hrdata,
  // Straps and circuits
  input wire logic [NPORTS-1:0]                     dte_strap,
  input wire logic [NPORTS-1:0]                     diff_strap,
  input wire logic [NPORTS-1:0][msp_pkg::NCIRC-1:0] pin_in,
  input wire msp_pkg::msp_pins_t [NPORTS-1:0]       pin_drv
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus waited or answered an error");
  AST_UNMAPPED_ZERO: assert property (hsel && htrans[1] && hready && !hwrite && haddr[31:6] != '0 |=> hrdata == '0)
    else $error("unmapped read returned data");
  AST_DTE_DIR: assert property (dte_strap[0] && $past(dte_strap[0], 4)
    |-> !pin_drv[0].oe_a[msp_pkg::C_CTS] && !pin_drv[0].oe_a[msp_pkg::C_RXD])
    else $error("terminal end drove a data set circuit");
  AST_DCE_DIR: assert property (!dte_strap[2] && !$past(dte_strap[2], 4)
    |-> !pin_drv[2].oe_a[msp_pkg::C_TXD] && !pin_drv[2].oe_a[msp_pkg::C_RTS])
    else $error("data set end drove a terminal circuit");
  AST_SE_NO_B: assert property (!diff_strap[0] && !$past(diff_strap[0], 4) |-> pin_drv[0].oe_b == '0)
    else $error("single-ended port drove a b leg");
  AST_PAIR_INV: assert property (pin_drv[3].out_b == ~pin_drv[3].out_a)
    else $error("b leg not the inverse of a leg");
  AST_DIFF_UNUSED: assert property (diff_strap[2] && $past(diff_strap[2], 4) |-> !pin_drv[2].oe_a[msp_pkg::C_DSR])
    else $error("differential port drove an unused circuit");
  AST_TX_LAUNCH: assert property ($rose(pin_in[1][msp_pkg::C_SCT]) |=> $stable(pin_drv[1].out_a[msp_pkg::C_TXD])[*4])
    else $error("transmit data moved near the rising clock");
endmodule
bind msp_top msp_top_checker #(.NPORTS(NPORTS), .CLK_HZ(CLK_HZ)) chk_u (.ref_clk, .reset, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .dte_strap, .diff_strap, .pin_in, .pin_drv);
`default_nettype wire

// file: testbench/msp_far_end.sv
/*
  Far-end equipment: loops each port's transmitted data back and supplies a 200 ns link clock.
  Assumes an undriven data line idles at mark.
*/
`timescale 1ns/1ps
`default_nettype none
module msp_far_end #(
  parameter int NP = 4
) (
  // Device side
  input wire msp_pkg::msp_pins_t [NP-1:0]      pin_drv,
  // Returned circuits
  output logic [NP-1:0][msp_pkg::NCIRC-1:0]    pin_in
);
  logic lclk = 1'b0;
  // A synchronous link clock runs continuously, as the idle fill is sent without pause.
  always #100 lclk = ~lclk;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pin_in[p] = '1;
      pin_in[p][msp_pkg::C_SCT] = lclk;
      pin_in[p][msp_pkg::C_SCR] = lclk;
      pin_in[p][msp_pkg::C_ETC] = lclk;
      pin_in[p][msp_pkg::C_RXD] = pin_drv[p].oe_a[msp_pkg::C_TXD] ? pin_drv[p].out_a[msp_pkg::C_TXD] : 1'b1;
      pin_in[p][msp_pkg::C_TXD] = pin_drv[p].oe_a[msp_pkg::C_RXD] ? pin_drv[p].out_a[msp_pkg::C_RXD] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
  Register-level bench for the four-port serial block with a looping far end.
  Assumes a zero-wait AHB-Lite slave and a shortened core clock figure for bit times.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                           ref_clk = 1'b0;
  logic                           reset = 1'b1;
  logic                           hsel = 1'b0;
  logic                           hwrite = 1'b0;
  logic [1:0]                     htrans = 2'h0;
  logic [2:0]                     hsize = 3'h2;
  logic [31:0]                    haddr = 32'h0;
  logic [31:0]                    hwdata = 32'h0;
  logic [31:0]                    hrdata;
  logic [31:0]                    r;
  logic                           hreadyout;
  logic                           hresp;
  logic [3:0]                     dte_strap = 4'h3;
  logic [3:0]                     diff_strap = 4'h4;
  logic [3:0][msp_pkg::NCIRC-1:0] pin_in;
  msp_pkg::msp_pins_t [3:0]       pin_drv;
  int                             miscompares = 0;
  int                             cmp_count = 0;
  int                             n;
  always #12.5 ref_clk = ~ref_clk;
  msp_top #(.NPORTS(4), .CLK_HZ(4000000)) dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dte_strap(dte_strap), .diff_strap(diff_strap), .pin_in(pin_in),
    .pin_drv(pin_drv));
  msp_far_end #(.NP(4)) far_u (.pin_drv(pin_drv), .pin_in(pin_in));
  task automatic report_and_stop(input bit gave_up);
    miscompares += gave_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic edge_rdy();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) report_and_stop(1'b1);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    r = hrdata;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    xfer(1'b0, 32'h40, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 32'h4, 32'h0);
    chk(32'(r[7:6]), 32'h1);
    xfer(1'b0, 32'h24, 32'h0);
    chk(32'(r[7:6]), 32'h2);
    xfer(1'b1, 32'h10, 32'h3);
    xfer(1'b1, 32'h50, 32'h5);
    xfer(1'b0, 32'h10, 32'h0);
    chk(r, 32'h1);
    xfer(1'b1, 32'h20, 32'h45);
    // Formats take stop lengths 1, 1.5, 2 and 1 in turn so every stop length is used.
    for (int f = 0; f < 4; f++) begin
      xfer(1'b1, 32'h0, 32'(32'h3b + (f << 7) + ((f % 3) << 9)));
      xfer(1'b0, 32'h0, 32'h0);
      chk(r, 32'(32'h3b + (f << 7) + ((f % 3) << 9)));
      xfer(1'b1, 32'h8, 32'(32'hd5 - f));
      n = 0;
      do begin
        xfer(1'b0, 32'h4, 32'h0);
        n++;
      end while (r[2] !== 1'b1 && n < 2000);
      if (r[2] !== 1'b1) report_and_stop(1'b1);
      chk(32'(r[5:3]), 32'h0);
      xfer(1'b0, 32'hc, 32'h0);
      chk(r, 32'((32'hd5 - f) & ((f == 3) ? 32'hff : 32'h7f)));
    end
    r = 32'(pin_drv[2].out_a);
    n = 0;
    repeat (124) begin
      @(posedge ref_clk);
      if (pin_drv[2].out_a[msp_pkg::C_SCT] !== r[msp_pkg::C_SCT]) n++;
      r = 32'(pin_drv[2].out_a);
    end
    chk(32'(n > 2 && n < 6), 32'h1);
    chk(32'(pin_drv[2].oe_a[msp_pkg::C_SCT]), 32'h1);
    chk(32'(pin_drv[1].oe_a[msp_pkg::C_SCT]), 32'h0);
    chk(32'(pin_drv[1].oe_a[msp_pkg::C_TXD]), 32'h1);
    chk(32'(pin_drv[2].oe_b), 32'hc2);
    report_and_stop(1'b0);
  end
endmodule
`default_nettype wire
